// ---- verilog/slave_timer_irq.v ----
// Interrupt acceptance, timer/event counter and cycle timing core
// Operation
// [R01] Pending requests are sampled once per machine cycle, at cycle end.
// [R02] External request: finish instruction, push PC and status, go to 3.
// [R03] One level; acceptance reopens at second cycle of return-restore.
// [R04] Overflow requests also wait while any service is active.
// [R05] External wins a tie; overflow stays latched until after return.
// [R06] Overflow acceptance pushes PC and status, goes to address 7.
// [R07] One 8-bit up-counter, loadable and readable, timer or event.
// [R08] Reset stops counting but keeps the counter value.
// [R09] Increment past maximum wraps to zero, sets flag and request.
// [R10] Branch-on-flag instruction or reset clears the overflow flag.
// [R11] Event-mode start counts falling edges of the event pin.
// [R12] At most one event per three machine cycles; source keeps pace.
// [R13] Timer mode counts once every 32 machine-cycle ticks.
// [R14] State clock is oscillator over three; five states per cycle.
// [R15] Every instruction takes one or two machine cycles.
// [R16] Reset clears PC, SP, bank, ports, enables, counter run, flags; the code sets both port latches to 8'hff instead.
// [R17] Reset source holds reset long enough after power-up.
// [R18] Step input low halts after current instruction; high runs next.
// [R19] Stepping logic lets the cycle marker clear the step input.
// [R20] Event mode preset to maximum: one edge requests address 7.
// [R21] Select and write strobe both low set pending and input-full.
// [R22] Separate enables; a disabled request is not vectored.
// [R23] Stop instruction and reset freeze the counter until a start.
`timescale 1ns/1ps
`include "slave_timer_map.vh"
module slave_timer_irq (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        sel_n,
  input  wire        wr_n,
  input  wire        event_pin,
  input  wire        step_n,
  output reg         cycle_marker,
  output reg         ibf_flag,
  output reg  [7:0]  port1_latch,
  output reg  [7:0]  port2_latch
);
  localparam [1:0] PH_IDLE = 2'd0;
  localparam [1:0] PH_C1   = 2'd1;
  localparam [1:0] PH_C2   = 2'd2;

  reg  [1:0]  osc_div_ff;
  reg  [2:0]  state_ff;
  reg  [1:0]  phase_ff;
  reg  [4:0]  op_ff;
  reg         op_is_call_ff;
  reg  [7:0]  arg_ff;
  reg         cmd_valid_ff;
  reg  [4:0]  cmd_op_ff;
  reg  [7:0]  cmd_arg_ff;
  reg  [11:0] pc_ff;
  reg  [2:0]  sp_ff;
  reg  [15:0] stack_ff [0:7];
  reg         bank_ff;
  reg         f0_ff;
  reg         f1_ff;
  reg         ext_en_ff;
  reg         tmr_en_ff;
  reg         ext_pend_ff;
  reg         tmr_pend_ff;
  reg         in_service_ff;
  reg         ovf_flag_ff;
  reg         jtf_taken_ff;
  reg         running_ff;
  reg         event_mode_ff;
  reg  [7:0]  cnt_ff;
  reg  [7:0]  acc_ff;
  reg  [4:0]  pre_ff;
  reg  [1:0]  gap_ff;
  reg         ev_seen_ff;
  reg         event_prev_ff;
  reg         strobe_prev_ff;

  // State clock tick and machine cycle end
  // [R14] divide by three, five states
  wire st_tick  = ce && (osc_div_ff == `OSC_DIV_LAST);
  wire cyc_end  = st_tick && (state_ff == `STATE_LAST);

  // [R15] one or two machine cycles
  wire two_cyc  = op_is_call_ff || (op_ff == `OP_JTF) ||
                  (op_ff == `OP_RETURN_RESTORE_STATUS);
  wire fin      = cyc_end && ((phase_ff == PH_C1 && !two_cyc) ||
                              phase_ff == PH_C2);
  wire boundary = cyc_end && (phase_ff == PH_IDLE || fin);
  wire fin_op   = fin && !op_is_call_ff;
  wire do_return_restore_status  = fin_op && (op_ff == `OP_RETURN_RESTORE_STATUS);

  // [R03] single level, reopened in second return cycle
  // [R22] enables gate vectoring
  // [R01] decided only at cycle end
  wire can_take = boundary && step_n && !in_service_ff;
  wire take_ext = can_take && ext_en_ff && ext_pend_ff;
  // [R04] [R05] overflow waits for service and loses a tie
  wire take_tmr = can_take && !take_ext && tmr_en_ff && tmr_pend_ff;
  // [R18] step input gates every new start
  wire take_cmd = boundary && step_n && !take_ext && !take_tmr &&
                  cmd_valid_ff;

  wire [2:0]  sp_dec   = sp_ff - 3'd1;
  wire [15:0] pop_word = stack_ff[sp_dec];
  wire [2:0]  sp_base  = do_return_restore_status ? sp_dec : sp_ff;
  wire [11:0] pc_base  = do_return_restore_status ? pop_word[11:0] :
                         (fin_op ? pc_ff + 12'd1 : pc_ff);
  wire        f0_base  = do_return_restore_status ? pop_word[13] : f0_ff;
  wire        bank_base = do_return_restore_status ? pop_word[12] : bank_ff;

  // Counter inputs
  // [R13] prescale by 32 machine cycles
  wire tmr_go   = cyc_end && running_ff && !event_mode_ff &&
                  (pre_ff == `PRESCALE_LAST);
  // [R11] falling edge of the event pin
  wire ev_fall  = event_prev_ff && !event_pin;
  // [R12] counted at most once per three cycles
  wire ev_go    = cyc_end && running_ff && event_mode_ff && ev_seen_ff &&
                  (gap_ff >= `EVENT_GAP_MIN);
  wire inc      = tmr_go || ev_go;
  wire load_cnt = fin_op && (op_ff == `OP_LOAD_CNT);
  // [R09] [R20] wrap from maximum raises flag and request
  wire ovf      = inc && !load_cnt && (cnt_ff == 8'hff);

  // [R21] both strobes low recognised on their arrival
  wire strobe   = !sel_n && !wr_n;
  wire ext_req  = strobe && !strobe_prev_ff;

  // APB decode
  wire setup    = psel && !penable;
  wire wr_go    = psel && penable && pwrite && pready;
  wire a_cmd    = (paddr == `OFS_CMD);
  wire a_ports  = (paddr == `OFS_PORTS);
  wire mapped   = a_cmd || a_ports || (paddr == `OFS_COUNT) ||
                  (paddr == `OFS_STATUS) || (paddr == `OFS_PCSP) ||
                  (paddr == `OFS_ACC);

  reg [31:0] rd_mux;
  reg [15:0] status_w;
  always @* begin
    status_w = 16'h0000;
    status_w[`ST_OVF]        = ovf_flag_ff;
    status_w[`ST_EXT_PEND]   = ext_pend_ff;
    status_w[`ST_TMR_PEND]   = tmr_pend_ff;
    status_w[`ST_IN_SERVICE] = in_service_ff;
    status_w[`ST_EXT_EN]     = ext_en_ff;
    status_w[`ST_TMR_EN]     = tmr_en_ff;
    status_w[`ST_RUNNING]    = running_ff;
    status_w[`ST_EVENT_MODE] = event_mode_ff;
    status_w[`ST_F0]         = f0_ff;
    status_w[`ST_F1]         = f1_ff;
    status_w[`ST_BANK]       = bank_ff;
    status_w[`ST_IBF]        = ibf_flag;
    status_w[`ST_CMD_BUSY]   = cmd_valid_ff;
    status_w[`ST_JTF_TAKEN]  = jtf_taken_ff;
    status_w[`ST_HALTED]     = !step_n;
    case (paddr)
      `OFS_CMD:    rd_mux = {16'h0000, cmd_arg_ff, 3'b000, cmd_op_ff};
      `OFS_COUNT:  rd_mux = {24'h000000, cnt_ff};
      `OFS_STATUS: rd_mux = {16'h0000, status_w};
      `OFS_PCSP:   rd_mux = {13'h0000, sp_ff, 4'h0, pc_ff};
      `OFS_PORTS:  rd_mux = {16'h0000, port2_latch, port1_latch};
      `OFS_ACC:    rd_mux = {24'h000000, acc_ff};
      default:     rd_mux = 32'h00000000;
    endcase
  end

  // Bus slave: answer in the first access cycle
  always @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= setup;
      // Error may only stand beside ready
      pslverr <= 1'b0;
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
        // Busy command slot refuses rather than silently dropping
        pslverr <= !mapped ||
                   (pwrite && !a_cmd && !a_ports) ||
                   (pwrite && a_cmd && cmd_valid_ff);
      end
    end
  end

  // Cycle timing and the cycle marker
  always @(posedge clk) begin
    if (rst) begin
      osc_div_ff   <= 2'd0;
      state_ff     <= 3'd0;
      cycle_marker <= 1'b0;
    end else if (ce) begin
      osc_div_ff <= (osc_div_ff == `OSC_DIV_LAST) ? 2'd0 :
                    osc_div_ff + 2'd1;
      if (st_tick) begin
        state_ff     <= (state_ff == `STATE_LAST) ? 3'd0 :
                        state_ff + 3'd1;
        // Marker spans state 1 of each cycle
        cycle_marker <= (state_ff == 3'd0);
      end
    end
  end

  // Command slot, port latches
  always @(posedge clk) begin
    if (rst) begin
      cmd_valid_ff <= 1'b0;
      cmd_op_ff    <= `OP_NOP;
      cmd_arg_ff   <= 8'h00;
      // [R16] ports back to input mode
      port1_latch  <= `RST_PORT;
      port2_latch  <= `RST_PORT;
    end else if (ce) begin
      if (take_cmd)
        cmd_valid_ff <= 1'b0;
      else if (wr_go && a_cmd && !cmd_valid_ff) begin
        cmd_valid_ff <= 1'b1;
        cmd_op_ff    <= pwdata[`CMD_OP_MSB:`CMD_OP_LSB];
        cmd_arg_ff   <= pwdata[`CMD_ARG_MSB:`CMD_ARG_LSB];
      end
      if (wr_go && a_ports) begin
        port1_latch <= pwdata[7:0];
        port2_latch <= pwdata[15:8];
      end
    end
  end

  // Sequencer, stack and status flags
  always @(posedge clk) begin
    if (rst) begin
      phase_ff      <= PH_IDLE;
      op_ff         <= `OP_NOP;
      op_is_call_ff <= 1'b0;
      arg_ff        <= 8'h00;
      // [R16] reset initialisation
      pc_ff         <= `RST_PC;
      sp_ff         <= 3'd0;
      bank_ff       <= 1'b0;
      f0_ff         <= 1'b0;
      f1_ff         <= 1'b0;
      ext_en_ff     <= 1'b0;
      tmr_en_ff     <= 1'b0;
      in_service_ff <= 1'b0;
      jtf_taken_ff  <= 1'b0;
      acc_ff        <= 8'h00;
    end else if (ce) begin
      if (cyc_end) begin
        if (phase_ff == PH_C1 && two_cyc)
          phase_ff <= PH_C2;
        else if (boundary)
          phase_ff <= (take_ext || take_tmr || take_cmd) ? PH_C1 : PH_IDLE;
      end
      // [R03] service ends at the end of the first cycle of return-restore
      if (cyc_end && phase_ff == PH_C1 && !op_is_call_ff &&
          op_ff == `OP_RETURN_RESTORE_STATUS)
        in_service_ff <= 1'b0;
      pc_ff   <= pc_base;
      sp_ff   <= sp_base;
      f0_ff   <= f0_base;
      bank_ff <= bank_base;
      if (fin_op) begin
        case (op_ff)
          `OP_EN_EXT:   ext_en_ff <= 1'b1;
          `OP_DIS_EXT:  ext_en_ff <= 1'b0;
          `OP_EN_TMR:   tmr_en_ff <= 1'b1;
          `OP_DIS_TMR:  tmr_en_ff <= 1'b0;
          // [R07] read counter into accumulator
          `OP_READ_CNT: acc_ff <= cnt_ff;
          // [R10] branch tests the flag
          `OP_JTF:      jtf_taken_ff <= ovf_flag_ff;
          `OP_SEL_RB0:  bank_ff <= 1'b0;
          `OP_SEL_RB1:  bank_ff <= 1'b1;
          `OP_CLR_F0:   f0_ff <= 1'b0;
          `OP_CPL_F0:   f0_ff <= !f0_ff;
          `OP_CLR_F1:   f1_ff <= 1'b0;
          `OP_CPL_F1:   f1_ff <= !f1_ff;
          default:      acc_ff <= acc_ff;
        endcase
      end
      if (take_ext || take_tmr) begin
        // [R02] [R06] push PC and status high bits, then vector
        stack_ff[sp_base] <= {2'b00, f0_base, bank_base, pc_base};
        sp_ff         <= sp_base + 3'd1;
        pc_ff         <= take_ext ? `VEC_EXT : `VEC_TMR;
        in_service_ff <= 1'b1;
        op_is_call_ff <= 1'b1;
        op_ff         <= `OP_NOP;
      end else if (take_cmd) begin
        op_is_call_ff <= 1'b0;
        op_ff         <= cmd_op_ff;
        arg_ff        <= cmd_arg_ff;
      end
    end
  end

  // Requests, flags and the counter
  always @(posedge clk) begin
    if (rst) begin
      ext_pend_ff    <= 1'b0;
      tmr_pend_ff    <= 1'b0;
      ibf_flag       <= 1'b0;
      // [R10] [R16] reset clears the overflow flag
      ovf_flag_ff    <= 1'b0;
      // [R08] [R23] reset stops counting, value kept
      running_ff     <= 1'b0;
      event_mode_ff  <= 1'b0;
      pre_ff         <= 5'h00;
      gap_ff         <= 2'd0;
      ev_seen_ff     <= 1'b0;
      event_prev_ff  <= 1'b1;
      strobe_prev_ff <= 1'b0;
    end else if (ce) begin
      event_prev_ff  <= event_pin;
      strobe_prev_ff <= strobe;
      // [R21] new request sets pending and input-full; set wins
      if (ext_req)
        ext_pend_ff <= 1'b1;
      else if (take_ext)
        ext_pend_ff <= 1'b0;
      if (ext_req)
        ibf_flag <= 1'b1;
      else if (fin_op && op_ff == `OP_IN_DBB)
        ibf_flag <= 1'b0;
      // [R05] overflow request stays latched until taken
      if (ovf)
        tmr_pend_ff <= 1'b1;
      else if (take_tmr)
        tmr_pend_ff <= 1'b0;
      // [R10] branch clears flag, a fresh overflow wins
      if (ovf)
        ovf_flag_ff <= 1'b1;
      else if (fin_op && op_ff == `OP_JTF)
        ovf_flag_ff <= 1'b0;
      if (cyc_end)
        pre_ff <= pre_ff + 5'h01;
      if (ev_go)
        gap_ff <= 2'd0;
      else if (cyc_end && gap_ff != 2'd3)
        gap_ff <= gap_ff + 2'd1;
      // [R12] extra edges inside the gap merge into one count
      if (ev_fall && running_ff && event_mode_ff)
        ev_seen_ff <= 1'b1;
      else if (ev_go)
        ev_seen_ff <= 1'b0;
      if (fin_op) begin
        case (op_ff)
          // [R11] event mode start
          `OP_START_EVENT: begin
            running_ff    <= 1'b1;
            event_mode_ff <= 1'b1;
            ev_seen_ff    <= 1'b0;
            gap_ff        <= 2'd3;
          end
          // [R13] timer mode start restarts the prescaler
          `OP_START_TIMER: begin
            running_ff    <= 1'b1;
            event_mode_ff <= 1'b0;
            pre_ff        <= 5'h00;
          end
          // [R23] stop freezes the counter
          `OP_STOP:        running_ff <= 1'b0;
          default:         running_ff <= running_ff;
        endcase
      end
    end
  end

  // Counter holds no reset so its value survives one
  // [R07] [R08] [R09] load beats increment; wrap is natural
  always @(posedge clk) begin
    if (ce) begin
      if (load_cnt)
        cnt_ff <= arg_ff;
      else if (inc)
        cnt_ff <= cnt_ff + 8'h01;
    end
  end

endmodule // slave_timer_irq

// ---- verilog/slave_timer_map.vh ----
// Offsets, fields, opcodes and timing counts of the timer/interrupt block
`ifndef SLAVE_TIMER_MAP_VH
`define SLAVE_TIMER_MAP_VH
`define OFS_CMD        8'h00
`define OFS_COUNT      8'h04
`define OFS_STATUS     8'h08
`define OFS_PCSP       8'h0c
`define OFS_PORTS      8'h10
`define OFS_ACC        8'h14
`define CMD_OP_LSB     0
`define CMD_OP_MSB     4
`define CMD_ARG_LSB    8
`define CMD_ARG_MSB    15
`define ST_OVF         0
`define ST_EXT_PEND    1
`define ST_TMR_PEND    2
`define ST_IN_SERVICE  3
`define ST_EXT_EN      4
`define ST_TMR_EN      5
`define ST_RUNNING     6
`define ST_EVENT_MODE  7
`define ST_F0          8
`define ST_F1          9
`define ST_BANK        10
`define ST_IBF         11
`define ST_CMD_BUSY    12
`define ST_JTF_TAKEN   13
`define ST_HALTED      14
`define OP_NOP         5'h00
`define OP_EN_EXT      5'h01
`define OP_DIS_EXT     5'h02
`define OP_EN_TMR      5'h03
`define OP_DIS_TMR     5'h04
`define OP_START_EVENT 5'h05
`define OP_START_TIMER 5'h06
`define OP_STOP        5'h07
`define OP_LOAD_CNT    5'h08
`define OP_READ_CNT    5'h09
`define OP_JTF         5'h0a
`define OP_RETURN_RESTORE_STATUS        5'h0b
`define OP_SEL_RB0     5'h0c
`define OP_SEL_RB1     5'h0d
`define OP_CLR_F0      5'h10
`define OP_CPL_F0      5'h11
`define OP_CLR_F1      5'h12
`define OP_CPL_F1      5'h13
`define OP_IN_DBB      5'h14
`define OSC_DIV_LAST   2'd2
`define STATE_LAST     3'd4
`define PRESCALE_LAST  5'h1f
`define EVENT_GAP_MIN  2'd2
`define VEC_EXT        12'h003
`define VEC_TMR        12'h007
`define RST_PC         12'h000
`define RST_PORT       8'hff
`endif

// ---- testbench/slave_timer_irq_properties.sv ----
// Port assertions for the timer and interrupt block
`timescale 1ns/1ps
`include "slave_timer_map.vh"
module slave_timer_irq_properties (
  input wire       clk,
  input wire       rst,
  input wire       ce,
  input wire       psel,
  input wire       penable,
  input wire       pwrite,
  input wire [7:0] paddr,
  input wire       pready,
  input wire       pslverr,
  input wire       sel_n,
  input wire       wr_n,
  input wire       cycle_marker,
  input wire       ibf_flag,
  input wire [7:0] port1_latch,
  input wire [7:0] port2_latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);
  wire port_wr = psel && penable && pwrite && paddr == `OFS_PORTS;

  marker_width_a:
    assert property ($rose(cycle_marker) |->
      cycle_marker[*3] ##1 !cycle_marker) else $error("marker width");
  marker_gap_a:
    assert property ($fell(cycle_marker) |-> !cycle_marker[*8])
      else $error("marker gap short");
  marker_period_a:
    assert property ($rose(cycle_marker) |-> ##15 $rose(cycle_marker))
      else $error("machine cycle not 15 clocks");
  ibf_set_a:
    assert property ($fell(sel_n || wr_n) |-> ##[1:3] ibf_flag)
      else $error("strobe left ibf clear");
  reset_ports_a:
    assert property (disable iff (1'b0) rst && ce |=>
      port1_latch == 8'hff && port2_latch == 8'hff)
      else $error("ports not input after reset");
  reset_quiet_a:
    assert property (disable iff (1'b0) rst && ce |=>
      !pready && !ibf_flag && !cycle_marker)
      else $error("outputs active after reset");
  apb_answer_a:
    assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  // Reset edge may reload the latches, so it counts as a cause
  port_hold_a:
    assert property ($changed(port1_latch) || $changed(port2_latch) |->
      $past(port_wr) || $past(rst)) else $error("port latch moved");

  cover property ($rose(ibf_flag));
  cover property (pslverr);
  cover property (port_wr);
endmodule // slave_timer_irq_properties

bind slave_timer_irq slave_timer_irq_properties props (
  .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sel_n(sel_n), .wr_n(wr_n), .cycle_marker(cycle_marker),
  .ibf_flag(ibf_flag), .port1_latch(port1_latch),
  .port2_latch(port2_latch)
);

// ---- testbench/event_step_src.sv ----
// Event pin source and single-step flip-flop beside the block
`timescale 1ns/1ps
module event_step_src (
  input  wire  clk,
  input  wire  cycle_marker,
  input  wire  step_mode,
  output logic event_pin,
  output logic step_n
);
  logic go_ff = 1'b0;
  initial event_pin = 1'b1;
  initial step_n = 1'b1;
  always @(posedge clk) begin
    if (!step_mode || go_ff)
      step_n <= 1'b1;
    else if (cycle_marker)
      step_n <= 1'b0;
  end
  task automatic fall_edge();
    @(posedge clk) event_pin <= 1'b0;
    repeat (10) @(posedge clk);
    event_pin <= 1'b1;
    repeat (40) @(posedge clk);
  endtask
  // Release after a marker pulse so one cycle end sees step high
  task automatic step_once();
    int n;
    n = 0;
    while (cycle_marker !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (cycle_marker === 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    go_ff <= 1'b1;
    @(posedge clk) go_ff <= 1'b0;
  endtask
endmodule // event_step_src

// ---- testbench/testbench.sv ----
// Self-checking bench for the timer and interrupt block
`timescale 1ns/1ps
`include "slave_timer_map.vh"
module testbench;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, sel_n = 1'b1, wr_n = 1'b1, step_mode = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic        err;
  wire  [31:0] prdata;
  wire  [7:0]  p1, p2;
  wire         pready, pslverr, event_pin, step_n, marker, ibf;
  int          error_cnt = 0, check_count = 0, seed = 32'h3d70, m_cnt, k;
  logic [4:0]  ops [13] = '{`OP_EN_EXT, `OP_EN_TMR, `OP_CPL_F0,
    `OP_CPL_F1, `OP_SEL_RB1, `OP_NOP, `OP_CLR_F0, `OP_CPL_F0, `OP_DIS_EXT,
    `OP_DIS_TMR, `OP_CPL_F1, `OP_CLR_F1, `OP_SEL_RB0};
  logic [11:0] sts [13] = '{12'h010, 12'h030, 12'h130, 12'h330, 12'h730,
    12'h730, 12'h630, 12'h730, 12'h720, 12'h700, 12'h500, 12'h500, 12'h100};
  always #2 clk = ~clk;
  slave_timer_irq dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_n(sel_n),
    .wr_n(wr_n), .event_pin(event_pin), .step_n(step_n),
    .cycle_marker(marker), .ibf_flag(ibf), .port1_latch(p1),
    .port2_latch(p2));
  event_step_src pm (.clk(clk), .cycle_marker(marker),
    .step_mode(step_mode), .event_pin(event_pin), .step_n(step_n));

  task automatic test_done();
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      rd = prdata;
      err = pslverr;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string s, input logic [7:0] a,
                       input logic [31:0] m, e);
    apb(1'b0, a, 0);
    chk(s, e, rd & m);
  endtask
  // Slot is polled until the command is taken, then a fixed wait covers its run
  task automatic cmd(input logic [4:0] op, input logic [7:0] arg);
    int n;
    apb(1'b1, `OFS_CMD, {arg, 3'b000, op});
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 0);
      n++;
    end while (rd[`ST_CMD_BUSY] !== 1'b0 && n < 40);
    if (rd[`ST_CMD_BUSY] !== 1'b0) begin
      error_cnt++;
      test_done();
    end
    // Slot empties at start; longest command ends two cycles later
    repeat (32) @(posedge clk);
  endtask
  task automatic strobe();
    sel_n <= 1'b0;
    wr_n <= 1'b0;
    @(posedge clk);
    sel_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask
  task automatic after_reset();
    rdchk("status", `OFS_STATUS, 32'h0ff1, 0);
    rdchk("pc sp", `OFS_PCSP, 32'h7_0fff, 0);
    rdchk("ports", `OFS_PORTS, 32'hffff, 32'hffff);
  endtask

  initial begin
    // reset held well past its minimum
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    after_reset();
    apb(1'b0, 8'h18, 0);
    chk("unmapped", 1, err);
    apb(1'b1, `OFS_COUNT, 32'h5a);
    chk("read only", 1, err);
    for (k = 0; k < 4; k++) begin
      m_cnt = $random(seed) & 32'hff;
      apb(1'b1, `OFS_PORTS, m_cnt * 32'h101);
      rdchk("ports", `OFS_PORTS, 32'hffff, m_cnt * 32'h101);
      chk("port pins", m_cnt * 32'h101, {16'h0000, p2, p1});
      cmd(`OP_LOAD_CNT, m_cnt[7:0]);
      rdchk("count", `OFS_COUNT, 32'hff, m_cnt);
      cmd(`OP_READ_CNT, 8'h00);
      rdchk("acc", `OFS_ACC, 32'hff, m_cnt);
    end
    foreach (ops[j]) begin
      cmd(ops[j], 8'h00);
      rdchk("mode bits", `OFS_STATUS, 32'h0730, sts[j]);
    end
    cmd(`OP_EN_EXT, 8'h00);
    cmd(`OP_EN_TMR, 8'h00);
    cmd(`OP_LOAD_CNT, 8'hff);
    cmd(`OP_START_EVENT, 8'h00);
    step_mode <= 1'b1;
    repeat (40) @(posedge clk);
    apb(1'b1, `OFS_CMD, `OP_NOP);
    apb(1'b1, `OFS_CMD, `OP_NOP);
    chk("busy refusal", 1, err);
    sel_n <= 1'b0;
    wr_n <= 1'b0;
    @(posedge clk);
    sel_n <= 1'b1;
    wr_n <= 1'b1;
    pm.fall_edge();
    rdchk("wrap", `OFS_COUNT, 32'hff, 0);
    rdchk("pending", `OFS_STATUS, 32'h180f, 32'h1807);
    pm.step_once();
    repeat (60) @(posedge clk);
    rdchk("ext call", `OFS_PCSP, 32'h7_0fff, 32'h1_0003);
    rdchk("held", `OFS_STATUS, 32'h100e, 32'h100c);
    step_mode <= 1'b0;
    repeat (40) @(posedge clk);
    cmd(`OP_RETURN_RESTORE_STATUS, 8'h00);
    repeat (60) @(posedge clk);
    rdchk("timer call", `OFS_PCSP, 32'h7_0fff, 32'h1_0007);
    rdchk("in service", `OFS_STATUS, 32'h000d, 32'h0009);
    cmd(`OP_JTF, 8'h00);
    rdchk("branch", `OFS_STATUS, 32'h2001, 32'h2000);
    cmd(`OP_IN_DBB, 8'h00);
    cmd(`OP_RETURN_RESTORE_STATUS, 8'h00);
    rdchk("idle", `OFS_STATUS, 32'h080e, 0);
    rdchk("sp", `OFS_PCSP, 32'h7_0000, 0);
    cmd(`OP_DIS_EXT, 8'h00);
    strobe();
    rdchk("no vector", `OFS_STATUS, 32'h000e, 32'h0002);
    cmd(`OP_LOAD_CNT, 8'h00);
    cmd(`OP_START_TIMER, 8'h00);
    repeat (1500) @(posedge clk);
    m_cnt = 1500 / 480;
    apb(1'b0, `OFS_COUNT, 0);
    chk("rate", 1, rd[7:0] == m_cnt || rd[7:0] == m_cnt + 1);
    cmd(`OP_STOP, 8'h00);
    apb(1'b0, `OFS_COUNT, 0);
    m_cnt = rd[7:0];
    repeat (1000) @(posedge clk);
    rdchk("stopped", `OFS_COUNT, 32'hff, m_cnt);
    cmd(`OP_START_TIMER, 8'h00);
    // Frozen clock enable must keep the timer from advancing
    ce <= 1'b0;
    repeat (1000) @(posedge clk);
    ce <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `OFS_COUNT, 0);
    chk("kept", 1, rd[7:0] == m_cnt || rd[7:0] == m_cnt + 1);
    m_cnt = rd[7:0];
    repeat (1000) @(posedge clk);
    rdchk("halted", `OFS_COUNT, 32'hff, m_cnt);
    after_reset();
    test_done();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule // testbench
